// ===== rrtad_decode.sv
// Purpose: address decode for ROM, RAM, port registers and interval timer
// Assumes: bus inputs are synchronous to clk_i; one bus cycle per clock; port pins are asynchronous
// Notes:   read data appears two clocks after the access edge; ROM and RAM arrays are external
`timescale 1ns/1ns
`default_nettype none
`include "rrtad_map.svh"

// Notes on behaviour
// - in the I/O-timer region A2 low picks port registers, A2 high picks timer.
// - A1..A0 pick port A data, A direction, B data, B direction; all read/write.
// - timer write takes prescale from A1..A0: divide by 1, 8, 64, 1024.
// - on any timer access A3 high enables, low disables timer interrupt onto port B pin 7.
// - timer read returns count when A0 low, flag when A0 high; A1 ignored.
// - ROM answers one distinct nonzero select pattern, ignoring A6 to A9.
// - selects all low: A9 low is RAM, high is I/O-timer; A8..A6 match chip code.
// - flag read puts flag on bit 7 and zeros on bits 0 to 6.
// - any timer access after expiry clears the flag; a read in the expiry cycle does not, a write does.
// - direction one makes a pin output, except port B pins masked as chip selects; data read mixes pin levels and latch.
// - timer counts down at the interval, then flags, reads all ones, runs per clock.
module rrtad_decode #(
    parameter logic [2:0] CHIP_NUM     = 3'h1, // position among chips, 1 to 7
    parameter bit         CS_FIRST_ON_PIN  = 1'b1, // mask option: port B bit 6 is first chip select
    parameter bit         CS_SECOND_ON_PIN = 1'b1  // mask option: port B bit 5 is second chip select
) (
    input  wire logic                   clk_i,       // phase-two bus clock, 25 MHz
    input  wire logic                   reset_n_i,   // async reset, active low
    input  wire rrtad_pkg::rrtad_addr_t addr_i,      // address A9..A0
    input  wire logic                   rom_region_select_i, // ROM select line
    input  wire logic                   rw_i,        // 1 read, 0 write
    input  wire rrtad_pkg::rrtad_byte_t data_i,      // data bus in
    output var  rrtad_pkg::rrtad_byte_t data_o,      // data bus out
    output var  logic                   data_oe_o,   // data bus drive enable
    input  wire rrtad_pkg::rrtad_byte_t port_a_i,    // port A pin levels
    output var  rrtad_pkg::rrtad_byte_t port_a_o,    // port A pin drive
    output var  rrtad_pkg::rrtad_byte_t port_a_oe_o, // port A drive enables
    input  wire rrtad_pkg::rrtad_byte_t port_b_i,    // port B pin levels, bits 6/5 are chip selects if masked
    output var  rrtad_pkg::rrtad_byte_t port_b_o,    // port B pin drive
    output var  rrtad_pkg::rrtad_byte_t port_b_oe_o, // port B drive enables
    output var  rrtad_pkg::rrtad_addr_t mem_addr_o,  // array address
    output var  logic                   rom_rd_o,    // ROM read strobe
    output var  logic                   ram_rd_o,    // RAM read strobe
    output var  logic                   ram_wr_o,    // RAM write strobe
    output var  rrtad_pkg::rrtad_byte_t ram_wdata_o, // RAM write data
    input  wire rrtad_pkg::rrtad_byte_t rom_data_i,  // ROM data, valid in the clock that rom_rd_o is high
    input  wire rrtad_pkg::rrtad_byte_t ram_data_i   // RAM data, valid in the clock that ram_rd_o is high
);
    import rrtad_pkg::*;

    typedef struct packed {
        rrtad_byte_t pa_latch;
        rrtad_byte_t pa_dir;
        rrtad_byte_t pb_latch;
        rrtad_byte_t pb_dir;
        logic        irq_en;
        rrtad_byte_t pa_s1;
        rrtad_byte_t pa_s2;
        rrtad_byte_t pb_s1;
        rrtad_byte_t pb_s2;
        rrtad_src_t  src;
        rrtad_byte_t reg_rd;
        rrtad_byte_t data;
        logic        data_oe;
        rrtad_byte_t pb_o;
        rrtad_byte_t pb_oe;
        rrtad_addr_t mem_addr;
        logic        rom_rd;
        logic        ram_rd;
        logic        ram_wr;
        rrtad_byte_t ram_wdata;
    } rrtad_state_t;

    localparam rrtad_state_t RESET_STATE = '{
        pa_latch: `RRTAD_RST_BYTE, pa_dir: `RRTAD_RST_BYTE, pb_latch: `RRTAD_RST_BYTE,
        pb_dir: `RRTAD_RST_BYTE, irq_en: 1'b0, pa_s1: `RRTAD_RST_BYTE, pa_s2: `RRTAD_RST_BYTE,
        pb_s1: `RRTAD_RST_BYTE, pb_s2: `RRTAD_RST_BYTE, src: SRC_NONE, reg_rd: `RRTAD_RST_BYTE,
        data: `RRTAD_RST_BYTE, data_oe: 1'b0, pb_o: `RRTAD_RST_BYTE, pb_oe: `RRTAD_RST_BYTE,
        mem_addr: 10'h000, rom_rd: 1'b0, ram_rd: 1'b0, ram_wr: 1'b0, ram_wdata: `RRTAD_RST_BYTE};

    rrtad_state_t st;
    rrtad_state_t next_st;

    rrtad_tmr_if tmr_bus ();

    rrtad_timer u_timer (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .bus       (tmr_bus.tmr)
    );

    // pin level read back: input bits from the pin, output bits from the latch
    function automatic rrtad_byte_t port_view(input rrtad_byte_t pins, input rrtad_byte_t latch,
                                              input rrtad_byte_t dir);
        port_view = (pins & ~dir) | (latch & dir);
    endfunction

    // chip selects are bus lines on clk_i, read straight from the shared pins
    logic       cs_first;
    logic       cs_second;
    logic [2:0] sel_pat;
    logic [2:0] chip_code;
    logic       hit_rom;
    logic       hit_low;
    logic       hit_ram;
    logic       hit_io;
    logic       io_regs;
    logic       io_tmr;

    assign cs_first  = CS_FIRST_ON_PIN ? port_b_i[`RRTAD_PB_CS_FIRST] : 1'b0;
    assign cs_second = CS_SECOND_ON_PIN ? port_b_i[`RRTAD_PB_CS_SECOND] : 1'b0;
    assign sel_pat   = {cs_second, cs_first, rom_region_select_i};
    assign chip_code = CHIP_NUM - 3'h1;
    assign hit_rom   = (sel_pat == CHIP_NUM) && (CHIP_NUM != 3'h0);
    assign hit_low   = (sel_pat == 3'h0) && (addr_i[8:6] == chip_code);
    assign hit_ram   = hit_low && !addr_i[`RRTAD_A_RAM_OR_IO];
    assign hit_io    = hit_low && addr_i[`RRTAD_A_RAM_OR_IO];
    assign io_regs   = hit_io && !addr_i[`RRTAD_A_REG_OR_TMR];
    assign io_tmr    = hit_io && addr_i[`RRTAD_A_REG_OR_TMR];

    assign tmr_bus.wr      = io_tmr && !rw_i;
    assign tmr_bus.rd      = io_tmr && rw_i;
    assign tmr_bus.wdata   = data_i;
    assign tmr_bus.div_sel = addr_i[1:0];

    always_comb begin
        rrtad_byte_t pa_view;
        rrtad_byte_t pb_view;
        pa_view = port_view(st.pa_s2, st.pa_latch, st.pa_dir);
        pb_view = port_view(st.pb_s2, st.pb_latch, st.pb_dir);
        next_st = st;
        next_st.pa_s1 = port_a_i;
        next_st.pa_s2 = st.pa_s1;
        next_st.pb_s1 = port_b_i;
        next_st.pb_s2 = st.pb_s1;
        next_st.src   = SRC_NONE;
        next_st.reg_rd = `RRTAD_RST_BYTE;
        next_st.rom_rd = hit_rom && rw_i;
        next_st.ram_rd = hit_ram && rw_i;
        next_st.ram_wr = hit_ram && !rw_i;
        next_st.ram_wdata = data_i;
        next_st.mem_addr = hit_rom ? addr_i : {4'h0, addr_i[5:0]};
        if (hit_rom && rw_i) begin
            next_st.src = SRC_ROM;
        end
        if (hit_ram && rw_i) begin
            next_st.src = SRC_RAM;
        end
        if (io_regs) begin
            if (rw_i) begin
                next_st.src = SRC_REG;
                unique case (addr_i[1:0])
                    `RRTAD_PORT_A_DATA: next_st.reg_rd = pa_view;
                    `RRTAD_PORT_A_DIR:  next_st.reg_rd = st.pa_dir;
                    `RRTAD_PORT_B_DATA: next_st.reg_rd = pb_view;
                    `RRTAD_PORT_B_DIR:  next_st.reg_rd = st.pb_dir;
                endcase
            end else begin
                unique case (addr_i[1:0])
                    `RRTAD_PORT_A_DATA: next_st.pa_latch = data_i;
                    `RRTAD_PORT_A_DIR:  next_st.pa_dir = data_i;
                    `RRTAD_PORT_B_DATA: next_st.pb_latch = data_i;
                    `RRTAD_PORT_B_DIR:  next_st.pb_dir = data_i;
                endcase
            end
        end
        if (io_tmr) begin
            next_st.irq_en = addr_i[`RRTAD_A_IRQ_EN];
            if (rw_i) begin
                next_st.src = SRC_REG;
                // A1 plays no part in a timer read
                next_st.reg_rd = addr_i[0] ? {tmr_bus.flag, 7'h00} : tmr_bus.count;
            end
        end
        // second stage: array data is valid in its strobe's clock and is registered at the end of it
        unique case (st.src)
            SRC_NONE: next_st.data = `RRTAD_RST_BYTE;
            SRC_ROM:  next_st.data = rom_data_i;
            SRC_RAM:  next_st.data = ram_data_i;
            SRC_REG:  next_st.data = st.reg_rd;
        endcase
        next_st.data_oe = (st.src != SRC_NONE);
        // pins used as chip selects are never driven
        next_st.pb_o  = next_st.pb_latch;
        next_st.pb_oe = next_st.pb_dir;
        next_st.pb_oe[`RRTAD_PB_CS_FIRST]  = next_st.pb_dir[`RRTAD_PB_CS_FIRST] && !CS_FIRST_ON_PIN;
        next_st.pb_oe[`RRTAD_PB_CS_SECOND] = next_st.pb_dir[`RRTAD_PB_CS_SECOND] && !CS_SECOND_ON_PIN;
        if (st.irq_en && tmr_bus.flag) begin
            // pulled low only; the bit should be set as input for this use
            next_st.pb_o[`RRTAD_PB_IRQ]  = 1'b0;
            next_st.pb_oe[`RRTAD_PB_IRQ] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign data_o      = st.data;
    assign data_oe_o   = st.data_oe;
    assign port_a_o    = st.pa_latch;
    assign port_a_oe_o = st.pa_dir;
    assign port_b_o    = st.pb_o;
    assign port_b_oe_o = st.pb_oe;
    assign mem_addr_o  = st.mem_addr;
    assign rom_rd_o    = st.rom_rd;
    assign ram_rd_o    = st.ram_rd;
    assign ram_wr_o    = st.ram_wr;
    assign ram_wdata_o = st.ram_wdata;

    a_rom_write_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (hit_rom && !rw_i) |=> (!rom_rd_o && !ram_wr_o) ##1 !data_oe_o)
        else $error("write to ROM region produced activity");
    a_flag_read_bits: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (io_tmr && rw_i && addr_i[0]) |-> ##2 (data_oe_o && data_o[6:0] == 7'h00 && data_o[7] == $past(tmr_bus.flag, 2)))
        else $error("flag read not on bit 7 with zeros below");
    a_count_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (io_tmr && rw_i && !addr_i[0]) |-> ##2 (data_oe_o && data_o == $past(tmr_bus.count, 2)))
        else $error("timer count read wrong");
    a_dir_write_drives: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (io_regs && !rw_i && addr_i[1:0] == `RRTAD_PORT_A_DIR) |=> (port_a_oe_o == $past(data_i)))
        else $error("port A direction write not applied");
    a_irq_pin_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (st.irq_en && tmr_bus.flag) |=> (port_b_oe_o[7] && !port_b_o[7]))
        else $error("enabled interrupt did not pull pin low");
    a_ram_region: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (sel_pat == 3'h0 && addr_i[8:6] == chip_code && !addr_i[9] && !rw_i) |=> (ram_wr_o && !rom_rd_o))
        else $error("RAM write not decoded");
endmodule
`default_nettype wire

// ===== rrtad_decode_test.sv
// Purpose: self-checking bench for the address decoder
// Assumes: chip 3 of a seven-chip system, both shared pins masked as chip selects
// Notes:   cpu addresses are split onto the select pins the way the system wires them
`timescale 1ns/1ns
`default_nettype none
module rrtad_decode_test;
    import rrtad_pkg::*;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    rrtad_addr_t addr_i = 10'h1c0;
    logic        rom_region_select_i = 1'b0;
    logic        rw_i = 1'b1;
    rrtad_byte_t data_i = 8'h00, port_a_i = 8'h00, port_b_i = 8'h00;
    rrtad_byte_t data_o, port_a_o, port_a_oe_o, port_b_o, port_b_oe_o, ram_wdata_o, rom_data, ram_data;
    rrtad_addr_t mem_addr_o;
    logic        data_oe_o, rom_rd_o, ram_rd_o, ram_wr_o;
    rrtad_byte_t regs [4];
    rrtad_byte_t got, v;
    logic [15:0] a;
    integer      seed = 69, errors = 0, compares = 0, cycles = 0, i, j;
    always #20 clk_i = ~clk_i;
    rrtad_decode #(.CHIP_NUM(3'h3), .CS_FIRST_ON_PIN(1'b1), .CS_SECOND_ON_PIN(1'b1)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .rom_region_select_i(rom_region_select_i),
        .rw_i(rw_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .port_a_i(port_a_i),
        .port_a_o(port_a_o), .port_a_oe_o(port_a_oe_o), .port_b_i(port_b_i), .port_b_o(port_b_o),
        .port_b_oe_o(port_b_oe_o), .mem_addr_o(mem_addr_o), .rom_rd_o(rom_rd_o), .ram_rd_o(ram_rd_o),
        .ram_wr_o(ram_wr_o), .ram_wdata_o(ram_wdata_o), .rom_data_i(rom_data), .ram_data_i(ram_data));
    rrtad_mem_model mem (
        .clk_i(clk_i), .rom_rd_i(rom_rd_o), .ram_rd_i(ram_rd_o), .ram_wr_i(ram_wr_o),
        .mem_addr_i(mem_addr_o), .ram_wdata_i(ram_wdata_o), .rom_data_o(rom_data), .ram_data_o(ram_data));

    task automatic check(input rrtad_byte_t g, input rrtad_byte_t e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic check_bit(input logic g, input logic e);
        check({7'h00, g}, {7'h00, e});
    endtask
    // one bus cycle, then back to an address no chip decodes
    task automatic access(input logic [15:0] ca, input logic rw, input rrtad_byte_t wd);
        @(posedge clk_i);
        addr_i              <= ca[9:0];
        rom_region_select_i <= ca[10];
        port_b_i[6]         <= ca[11];
        port_b_i[5]         <= ca[12];
        rw_i                <= rw;
        data_i              <= wd;
        @(posedge clk_i);
        addr_i              <= 10'h1c0;
        rom_region_select_i <= 1'b0;
        port_b_i[6]         <= 1'b0;
        port_b_i[5]         <= 1'b0;
        rw_i                <= 1'b1;
    endtask
    task automatic read(input logic [15:0] ca, output rrtad_byte_t d);
        access(ca, 1'b1, 8'h00);
        @(posedge clk_i);
        #1;
        check_bit(data_oe_o, 1'b1);
        d = data_o;
        @(posedge clk_i);
        #1;
        check_bit(data_oe_o, 1'b0);
        @(posedge clk_i);
        #1;
    endtask
    task automatic quiet(input logic [15:0] ca, input logic rw);
        access(ca, rw, 8'h5a);
        repeat (3) begin
            @(posedge clk_i);
            #1;
            check_bit(data_oe_o | ram_wr_o | ram_rd_o | rom_rd_o, 1'b0);
        end
    endtask
    function automatic rrtad_byte_t pin_mix(input rrtad_byte_t pins, input rrtad_byte_t lat, input rrtad_byte_t dir);
        return (pins & ~dir) | (lat & dir);
    endfunction
    // count read k clocks after the load: first step one clock after the load, then every div
    function automatic rrtad_byte_t tmr_exp(input rrtad_byte_t val, input int div, input int k);
        return val - 8'((k - 2) / div + 1);
    endfunction
    function automatic rrtad_byte_t rom_exp(input logic [9:0] ra);
        return ra[7:0] ^ {ra[9:8], 6'h15};
    endfunction
    task automatic results;
        $display("counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end

    initial begin
        port_a_i = 8'($random(seed));
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1;
        check(port_a_oe_o, 8'h00);
        check(port_b_oe_o, 8'h00);
        read(16'h0281, got);
        check(got, 8'h00);
        read(16'h0283, got);
        check(got, 8'h00);
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i);
            port_a_i <= 8'($random(seed));
            port_b_i <= {1'(($random(seed))), 2'h0, 5'($random(seed))};
            for (j = 0; j < 4; j++) begin
                regs[j] = (j == 3) ? 8'($random(seed)) & 8'h7f : 8'($random(seed));
                access(16'h0280 | j[15:0], 1'b0, regs[j]);
            end
            read(16'h0280, got);
            check(got, pin_mix(port_a_i, regs[0], regs[1]));
            read(16'h0281, got);
            check(got, regs[1]);
            read(16'h0282, got);
            check(got & 8'h9f, pin_mix(port_b_i, regs[2], regs[3]) & 8'h9f);
            read(16'h0283, got);
            check(got, regs[3]);
            check(port_a_o, regs[0]);
            check(port_a_oe_o, regs[1]);
            check(port_b_oe_o, regs[3] & 8'h9f);
            check(port_b_o & 8'h9f, regs[2] & 8'h9f);
        end
        $display("test ports done");
        for (i = 0; i < 4; i++) begin
            v = 8'h80 | 8'($random(seed));
            access(16'h0284 | i[15:0], 1'b0, v);
            repeat (68) @(posedge clk_i);
            read(16'h0284 | 16'(i & 2), got);
            check(got, tmr_exp(v, (i == 3) ? 1024 : 1 << (3 * i), 70));
        end
        $display("test prescale done");
        access(16'h028c, 1'b0, 8'h03);
        repeat (4) @(posedge clk_i);
        #1;
        check_bit(port_b_oe_o[7], 1'b0);
        @(posedge clk_i);
        #1;
        check_bit(port_b_oe_o[7], 1'b1);
        check_bit(port_b_o[7], 1'b0);
        repeat (3) @(posedge clk_i);
        #1;
        read(16'h0284, got);
        check(got, 8'hfa);
        read(16'h0285, got);
        check(got, 8'h00);
        check_bit(port_b_oe_o[7], 1'b0);
        access(16'h0284, 1'b0, 8'h03);
        repeat (8) @(posedge clk_i);
        #1;
        check_bit(port_b_oe_o[7], 1'b0);
        read(16'h0287, got);
        check(got, 8'h80);
        read(16'h0285, got);
        check(got, 8'h00);
        access(16'h0284, 1'b0, 8'h03);
        repeat (2) @(posedge clk_i);
        read(16'h0285, got);
        check(got, 8'h00);
        read(16'h0285, got);
        check(got, 8'h80);
        access(16'h0284, 1'b0, 8'h03);
        read(16'h028c, got);
        check(got, tmr_exp(8'h03, 1, 2));
        check_bit(port_b_oe_o[7], 1'b1);
        $display("test interrupt done");
        for (i = 1; i < 8; i++) begin
            a = 16'he000 | 16'(i << 10) | 16'($random(seed) & 16'h03ff);
            if (i == 3) begin
                read(a, got);
                check(got, rom_exp(a[9:0]));
                quiet(a, 1'b0);
            end else begin
                quiet(a, 1'b1);
            end
        end
        $display("test rom done");
        for (i = 0; i < 4; i++) begin
            a = 16'h0080 | 16'($random(seed) & 16'h003f);
            v = 8'($random(seed));
            access(a, 1'b0, v);
            read(a, got);
            check(got, v);
            quiet(a ^ 16'h0240, 1'b1);
        end
        $display("test ram done");
        results();
    end
endmodule
`default_nettype wire

// ===== rrtad_map.svh
// Purpose: offsets, field positions, reset values and prescale counts for the address decoder
// Assumes: included by bare name from the decoder and timer files
// Notes:   definitions only
`ifndef RRTAD_MAP_SVH
`define RRTAD_MAP_SVH

// address bit positions
`define RRTAD_A_REG_OR_TMR  2
`define RRTAD_A_IRQ_EN      3
`define RRTAD_A_RAM_OR_IO   9

// port register codes on A1..A0 when A2 is low
`define RRTAD_PORT_A_DATA   2'h0
`define RRTAD_PORT_A_DIR    2'h1
`define RRTAD_PORT_B_DATA   2'h2
`define RRTAD_PORT_B_DIR    2'h3

// prescale divide codes on A1..A0 for a timer write
`define RRTAD_DIV_1         2'h0
`define RRTAD_DIV_8         2'h1
`define RRTAD_DIV_64        2'h2
`define RRTAD_DIV_1024      2'h3

// prescale terminal counts (divide minus one)
`define RRTAD_PRE_1         10'h000
`define RRTAD_PRE_8         10'h007
`define RRTAD_PRE_64        10'h03f
`define RRTAD_PRE_1024      10'h3ff

// reset values
`define RRTAD_RST_BYTE      8'h00
`define RRTAD_RST_PRE       10'h000

// flag position on a flag read
`define RRTAD_FLAG_BIT      7

// shared port B pins
`define RRTAD_PB_IRQ        7
`define RRTAD_PB_CS_FIRST   6
`define RRTAD_PB_CS_SECOND  5

`endif

// ===== rrtad_mem_model.sv
// Purpose: external ROM and RAM arrays answering the decoder's strobes
// Assumes: strobes and array address come from the decoder on clk_i
// Notes:   outside a strobe the data lines carry a changing pattern, never a stale byte
`timescale 1ns/1ns
`default_nettype none
module rrtad_mem_model (
    input  wire logic                   clk_i,       // bus clock
    input  wire logic                   rom_rd_i,    // rom read strobe
    input  wire logic                   ram_rd_i,    // ram read strobe
    input  wire logic                   ram_wr_i,    // ram write strobe
    input  wire rrtad_pkg::rrtad_addr_t mem_addr_i,  // array address
    input  wire rrtad_pkg::rrtad_byte_t ram_wdata_i, // ram write data
    output var  rrtad_pkg::rrtad_byte_t rom_data_o,  // rom data
    output var  rrtad_pkg::rrtad_byte_t ram_data_o   // ram data
);
    import rrtad_pkg::*;
    rrtad_byte_t ram [64];
    rrtad_byte_t noise = 8'h3c;
    always @(posedge clk_i) begin
        noise <= ~noise + 8'h01;
        if (ram_wr_i) begin
            ram[mem_addr_i[5:0]] <= ram_wdata_i;
        end
    end
    // rom content is a fixed function of the address so the bench can predict it
    always_comb begin
        rom_data_o = rom_rd_i ? (mem_addr_i[7:0] ^ {mem_addr_i[9:8], 6'h15}) : noise;
        ram_data_o = ram_rd_i ? ram[mem_addr_i[5:0]] : ~noise;
    end
endmodule
`default_nettype wire

// ===== rrtad_pkg.sv
// Purpose: shared types of the address decoder
// Assumes: nothing
// Notes:   constants live in rrtad_map.svh
package rrtad_pkg;
    typedef logic [7:0] rrtad_byte_t;
    typedef logic [9:0] rrtad_addr_t;
    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_ROM,
        SRC_RAM,
        SRC_REG
    } rrtad_src_t;
    typedef enum logic {
        TMR_SLOW,
        TMR_FAST
    } rrtad_tmr_mode_t;
endpackage

// ===== rrtad_timer.sv
// Purpose: interval timer with prescaler and expiry flag
// Assumes: one access per clock, strobes from the decoder
// Notes:   after expiry the count runs at full clock rate until the next write
`timescale 1ns/1ns
`default_nettype none
`include "rrtad_map.svh"
module rrtad_timer (
    input  wire logic    clk_i,     // bus clock
    input  wire logic    reset_n_i, // async reset, active low
    rrtad_tmr_if.tmr     bus        // timer access port
);
    import rrtad_pkg::*;

    typedef struct packed {
        rrtad_tmr_mode_t mode;
        logic [9:0]      pre;
        logic [9:0]      limit;
        rrtad_byte_t     count;
        logic            flag;
    } rrtad_tmr_state_t;

    rrtad_tmr_state_t st;
    rrtad_tmr_state_t next_st;

    function automatic logic [9:0] pre_limit(input logic [1:0] sel);
        unique case (sel)
            `RRTAD_DIV_1:    pre_limit = `RRTAD_PRE_1;
            `RRTAD_DIV_8:    pre_limit = `RRTAD_PRE_8;
            `RRTAD_DIV_64:   pre_limit = `RRTAD_PRE_64;
            `RRTAD_DIV_1024: pre_limit = `RRTAD_PRE_1024;
        endcase
    endfunction

    logic tick;
    assign tick = (st.mode == TMR_SLOW) && (st.pre == st.limit);

    always_comb begin
        next_st = st;
        unique case (st.mode)
            TMR_SLOW: begin
                next_st.pre = tick ? `RRTAD_RST_PRE : st.pre + 10'h001;
                if (tick) begin
                    if (st.count == `RRTAD_RST_BYTE) begin
                        next_st.flag = 1'b1;
                        next_st.mode = TMR_FAST;
                    end
                    next_st.count = st.count - 8'h01;
                end
            end
            TMR_FAST: begin
                next_st.count = st.count - 8'h01;
            end
        endcase
        // any access after expiry clears the flag; an expiry in the same cycle wins over a read, but a write still clears it
        if ((bus.rd || bus.wr) && st.mode == TMR_FAST) begin
            next_st.flag = 1'b0;
        end
        if (bus.wr) begin
            // pre starts at the limit so the first decrement comes one clock after the write
            next_st.count = bus.wdata;
            next_st.limit = pre_limit(bus.div_sel);
            next_st.pre   = pre_limit(bus.div_sel);
            next_st.mode  = TMR_SLOW;
            next_st.flag  = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '{mode: TMR_SLOW, pre: `RRTAD_RST_PRE, limit: `RRTAD_PRE_1, count: `RRTAD_RST_BYTE, flag: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign bus.count = st.count;
    assign bus.flag  = st.flag;

    a_expiry_sets_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (tick && st.count == 8'h00 && !bus.wr) |=> (st.flag && st.count == 8'hff && st.mode == TMR_FAST))
        else $error("expiry did not set flag with all ones");
    a_fast_decrement: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (st.mode == TMR_FAST && !bus.wr) |=> (st.count == $past(st.count) - 8'h01))
        else $error("count not decrementing each clock after expiry");
    a_write_prescale: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (bus.wr && bus.div_sel == `RRTAD_DIV_8) |=> (st.count == $past(bus.wdata) && !st.flag) ##8 (st.count == $past(bus.wdata, 9) - 8'h01))
        else $error("divide by eight prescale wrong");
    a_flag_clear_access: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (st.flag && bus.rd && !bus.wr) |=> !st.flag)
        else $error("flag not cleared by timer read");
endmodule
`default_nettype wire

// ===== rrtad_tmr_if.sv
// Purpose: access strobes between the decoder and the interval timer
// Assumes: both ends on clk_i
// Notes:   strobes are combinational in the access cycle
`timescale 1ns/1ns
`default_nettype none
interface rrtad_tmr_if;
    logic                wr;
    logic                rd;
    rrtad_pkg::rrtad_byte_t wdata;
    logic [1:0]          div_sel;
    rrtad_pkg::rrtad_byte_t count;
    logic                flag;
    modport ctrl (output wr, output rd, output wdata, output div_sel, input count, input flag);
    modport tmr  (input wr, input rd, input wdata, input div_sel, output count, output flag);
endinterface
`default_nettype wire
